// File: bench/atb_apb_peer.sv
// APB peripheral stand-in that answers every select of the bridge.
// Assumes the bridge clock; it adds no wait states of its own.
module atb_apb_peer (
	input wire logic core_clk,
	input wire atb_pkg::atb_sel_t psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire atb_pkg::atb_word_t pwdata,
	output atb_pkg::atb_word_t prdata,
	output atb_pkg::atb_word_t lastWr
);
	import atb_pkg::*;
	atb_word_t idlePat = 32'h0f0f_0f0f;
	logic act;
	assign act = (|psel) & penable;
	// plain APB answer
	// Idle data toggles so a sample outside the access never matches
	assign prdata = act ? (paddr ^ 32'h3c3c_a5a5) : idlePat;
	always_ff @(posedge core_clk) begin
		idlePat <= ~idlePat;
		if (act && pwrite) begin
			lastWr <= pwdata;
		end
	end
endmodule : atb_apb_peer

// File: bench/tb_top.sv
// Bench for the AHB to APB bridge: registers, waits and selects.
// Assumes the map header and the APB peer model.
`include "atb_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import atb_pkg::*;
	logic core_clk = 0;
	logic rst = 1;
	logic hsel = 0;
	logic hwrite = 0;
	logic hreadyIn = 1;
	logic [31:0] haddr = 0;
	logic [1:0] htrans = 0;
	atb_word_t hwdata = 0;
	atb_word_t hrdata, pwdata, prdata, lastWr, rd;
	atb_sel_t psel, selSeen;
	logic hreadyOut, hresp, penable, pwrite;
	logic [31:0] paddr;
	int err_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int k;
	atb_word_t rv[3] = '{`ATB_RST_WAIT_LOW, `ATB_RST_WAIT_MID,
		`ATB_RST_WAIT_HIGH};
	logic [31:0] ta[12] = '{32'hfffd_1000, 32'hfffd_3000, 32'hfffd_4000,
		32'hfffd_5000, 32'hfffe_a000, 32'hffff_5000, 32'hfffe_4800,
		32'hfffe_5c00, 32'hfffe_5000, 32'hfffe_000c, 32'hfffd_2000,
		32'hffff_4000};
	int ts[12] = '{1, 3, 4, 5, 26, 37, 49, 51, -1, -1, -1, -1};
	int tw[12] = '{0, 1, 2, 3, 1, 0, 1, 1, 0, 0, 0, 0};
	atb_bridge i_dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
		.hwdata, .hreadyIn, .hreadyOut, .hresp, .hrdata, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata);
	atb_apb_peer i_peer (.core_clk, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .lastWr);
	initial forever #5 core_clk = ~core_clk;
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One single transfer; k counts cycles until ready returns
	task automatic acc(input logic [31:0] a, input logic w,
		input atb_word_t d);
		@(posedge core_clk);
		hsel <= 1;
		htrans <= `ATB_HTRANS_NSEQ;
		haddr <= a;
		hwrite <= w;
		@(posedge core_clk);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		k = 0;
		selSeen = '0;
		do begin
			@(negedge core_clk);
			k++;
			selSeen |= psel;
		end while (hreadyOut !== 1'b1 && k < 20);
		rd = hrdata;
		chk(64'(hresp), 64'(`ATB_HRESP_OKAY));
	endtask : acc
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 0;
		for (int i = 0; i < 3; i++) begin
			acc(32'hfffe_0000 + 32'(4 * i), 0, 0);
			chk(64'(rd), 64'(rv[i]));
		end
		$display("test reset values done");
		acc(32'hfffe_0004, 1, 32'ha5a5_5a5a);
		acc(32'hfffe_0004, 0, 0);
		chk(64'(rd), 64'h0_a5a5_5a5a);
		acc(32'hfffe_0004, 1, 0);
		// Only the peripherals under test get extra waits
		acc(32'hfffe_0008, 1, 32'h0000_0e40);
		acc(32'hfffe_000c, 1, 32'hffff_ffff);
		$display("test register access done");
		for (int i = 0; i < 12; i++) begin
			if (ts[i] >= 0) begin
				acc(ta[i], 1, ta[i] ^ 32'h1111_0000);
				chk(64'(lastWr), 64'(ta[i] ^ 32'h1111_0000));
				chk(64'(k), 64'(3 + tw[i]));
			end
			acc(ta[i], 0, 0);
			chk(64'(rd), ts[i] < 0 ? 0 : 64'(ta[i] ^ 32'h3c3c_a5a5));
			chk(64'(selSeen), ts[i] < 0 ? 0 : 64'h1 << ts[i]);
			if (ts[i] >= 0) begin
				chk(64'(k), 64'(3 + tw[i]));
			end
		end
		$display("test wait and select done");
		@(posedge core_clk);
		rst <= 1;
		repeat (2) @(posedge core_clk);
		rst <= 0;
		acc(32'hfffe_0008, 0, 0);
		chk(64'(rd), 64'(`ATB_RST_WAIT_HIGH));
		$display("test second reset done");
		summarize();
	end
endmodule : tb_top

// File: inc/atb_map.svh
// Bridge register map, reset values and address decode constants.
// Included by the package, the bridge and the bench; definitions only.
`ifndef ATB_MAP_SVH
`define ATB_MAP_SVH
`define ATB_OFF_WAIT_LOW 8'h00
`define ATB_OFF_WAIT_MID 8'h04
`define ATB_OFF_WAIT_HIGH 8'h08
`define ATB_RST_WAIT_LOW 32'h0050_0500
`define ATB_RST_WAIT_MID 32'h0000_0000
`define ATB_RST_WAIT_HIGH 32'h0050_0000
`define ATB_PAGE_LOW 16'hfffe
`define ATB_PAGE_MID 16'hffff
`define ATB_PAGE_HIGH 16'hfffd
`define ATB_SLOT_BRIDGE 4'h0
// Reserved 4KB slots per page, one bit per slot index
`define ATB_RSV_HIGH 16'h60c5
`define ATB_RSV_LOW 16'h0004
`define ATB_RSV_MID 16'h40d1
`define ATB_CARD_SLOT 4'h4
`define ATB_CARD_SLOT_B 4'h5
`define ATB_SLOT_COUNT 16
`define ATB_SEL_COUNT 52
`define ATB_SEL_CARD0 6'd48
`define ATB_HTRANS_NSEQ 2'b10
`define ATB_HRESP_OKAY 1'b0
`endif

// File: inc/atb_pkg.sv
// Types shared by the bridge.
// Assumes the map header is on the include path.
`include "atb_map.svh"
package atb_pkg;
	typedef enum logic [1:0] {
		ATB_IDLE = 2'b00,
		ATB_SETUP = 2'b01,
		ATB_ACCESS = 2'b11,
		ATB_REGS = 2'b10
	} atb_state_t;
	typedef logic [31:0] atb_word_t;
	typedef logic [`ATB_SEL_COUNT-1:0] atb_sel_t;
endpackage : atb_pkg

// File: verilog/atb_bridge.sv
// AHB slave to APB master bridge with per-slot APB wait insertion.
// Assumes one AHB master, single clock, APB peripherals on the same clock.
`include "atb_map.svh"

//Behaviour
// - Act as AHB slave; run each peripheral access as an APB transfer.
// - Wait code 00 gives the basic two-cycle APB access.
// - Codes 01, 10, 11 add one, two, three wait cycles.
// - Each wait register holds sixteen 2-bit codes, slot n at bits 2n+1:2n.
// - Reset values 0x00500500, zero and 0x00500000.
// - Wait code chosen by page and 4KB slot index of the address.
// - 4KB selects; card region split 2KB,2KB,1KB,1KB; reserved selects none.
// - Wait registers at offsets 0x00, 0x04, 0x08, 32-bit read/write.
module atb_bridge (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire atb_pkg::atb_word_t hwdata,
	input wire logic hreadyIn,
	output logic hreadyOut,
	output logic hresp,
	output atb_pkg::atb_word_t hrdata,
	output atb_pkg::atb_sel_t psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output atb_pkg::atb_word_t pwdata,
	input wire atb_pkg::atb_word_t prdata
);
	import atb_pkg::*;

	atb_state_t stateReg, stateNext;
	atb_word_t waitLowReg, waitLowNext;
	atb_word_t waitMidReg, waitMidNext;
	atb_word_t waitHighReg, waitHighNext;
	logic [1:0] waitCntReg, waitCntNext;
	logic hreadyReg, hreadyNext;
	atb_word_t hrdataReg, hrdataNext;
	atb_sel_t pselReg, pselNext;
	logic penableReg, penableNext;
	logic pwriteReg, pwriteNext;
	logic [31:0] paddrReg, paddrNext;
	atb_word_t pwdataReg, pwdataNext;
	logic [7:0] regOffReg, regOffNext;
	logic regWrReg, regWrNext;

	logic take;
	atb_sel_t decSel;
	logic [1:0] decWait;
	logic isRegs;
	logic [15:0] page;
	logic [3:0] slot;
	atb_word_t waitWord;

	assign take = hsel && hreadyIn && htrans[1];
	assign page = haddr[31:16];
	assign slot = haddr[15:12];

	always_comb begin
		case (page)
			`ATB_PAGE_LOW: waitWord = waitLowReg;
			`ATB_PAGE_MID: waitWord = waitMidReg;
			`ATB_PAGE_HIGH: waitWord = waitHighReg;
			default: waitWord = '0;
		endcase
		decWait = waitWord[{slot, 1'b0} +: 2];
	end

	// one select per 4KB slot of each page; card slots split further
	genvar gi;
	generate
		for (gi = 0; gi < 48; gi++) begin : g_sel
			localparam logic [15:0] PG = (gi < 16) ? `ATB_PAGE_HIGH :
				(gi < 32) ? `ATB_PAGE_LOW : `ATB_PAGE_MID;
			localparam logic [15:0] RSV = (gi < 16) ? `ATB_RSV_HIGH :
				(gi < 32) ? `ATB_RSV_LOW : `ATB_RSV_MID;
			localparam logic [3:0] SL = 4'(gi % 16);
			logic isCard;
			assign isCard = (PG == `ATB_PAGE_LOW) &&
				(SL == `ATB_CARD_SLOT || SL == `ATB_CARD_SLOT_B);
			// Bridge's own slot is served internally, never on APB
			// Reserved slots never raise a select
			assign decSel[gi] = (page == PG) && (slot == SL) && !isCard &&
				!RSV[SL] &&
				!(PG == `ATB_PAGE_LOW && SL == `ATB_SLOT_BRIDGE);
		end
	endgenerate
	// Card areas: 2KB, 2KB at slot 4; 1KB, 1KB at slot 5 upper half, lower half unused
	assign decSel[`ATB_SEL_CARD0] = (page == `ATB_PAGE_LOW) &&
		(slot == `ATB_CARD_SLOT) && !haddr[11];
	assign decSel[`ATB_SEL_CARD0+1] = (page == `ATB_PAGE_LOW) &&
		(slot == `ATB_CARD_SLOT) && haddr[11];
	assign decSel[`ATB_SEL_CARD0+2] = (page == `ATB_PAGE_LOW) &&
		(slot == `ATB_CARD_SLOT_B) && (haddr[11:10] == 2'b10);
	assign decSel[`ATB_SEL_CARD0+3] = (page == `ATB_PAGE_LOW) &&
		(slot == `ATB_CARD_SLOT_B) && (haddr[11:10] == 2'b11);
	assign isRegs = (page == `ATB_PAGE_LOW) && (slot == `ATB_SLOT_BRIDGE);

	always_comb begin
		stateNext = stateReg;
		waitLowNext = waitLowReg;
		waitMidNext = waitMidReg;
		waitHighNext = waitHighReg;
		waitCntNext = waitCntReg;
		hreadyNext = hreadyReg;
		hrdataNext = hrdataReg;
		pselNext = pselReg;
		penableNext = penableReg;
		pwriteNext = pwriteReg;
		paddrNext = paddrReg;
		pwdataNext = pwdataReg;
		regOffNext = regOffReg;
		regWrNext = regWrReg;
		case (stateReg)
			ATB_IDLE: begin
				hreadyNext = 1'b1;
				// take AHB transfer, launch APB setup
				if (take && isRegs) begin
					regOffNext = haddr[7:0];
					regWrNext = hwrite;
					hreadyNext = 1'b0;
					stateNext = ATB_REGS;
				end else if (take && (decSel != '0)) begin
					pselNext = decSel;
					paddrNext = haddr;
					pwriteNext = hwrite;
					waitCntNext = decWait;
					// stall the master for the whole APB transfer
					hreadyNext = 1'b0;
					stateNext = ATB_SETUP;
				end
				else if (take) begin
					// Unmapped or reserved: zero-wait OKAY, reads as zero
					hrdataNext = '0;
				end
			end
			ATB_SETUP: begin
				// Write data phase follows the address phase on AHB
				pwdataNext = hwdata;
				penableNext = 1'b1;
				stateNext = ATB_ACCESS;
			end
			ATB_ACCESS: begin
				if (waitCntReg != 2'b00) begin
					waitCntNext = waitCntReg - 2'b01;
				end else begin
					// data and ready together in final cycle
					hrdataNext = prdata;
					hreadyNext = 1'b1;
					pselNext = '0;
					penableNext = 1'b0;
					stateNext = ATB_IDLE;
				end
			end
			ATB_REGS: begin
				hreadyNext = 1'b1;
				hrdataNext = '0;
				stateNext = ATB_IDLE;
				case (regOffReg)
					`ATB_OFF_WAIT_LOW: begin
						hrdataNext = waitLowReg;
						if (regWrReg) waitLowNext = hwdata;
					end
					`ATB_OFF_WAIT_MID: begin
						hrdataNext = waitMidReg;
						if (regWrReg) waitMidNext = hwdata;
					end
					`ATB_OFF_WAIT_HIGH: begin
						hrdataNext = waitHighReg;
						if (regWrReg) waitHighNext = hwdata;
					end
					default: hrdataNext = '0;
				endcase
			end
			default: stateNext = ATB_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stateReg <= ATB_IDLE;
			waitLowReg <= `ATB_RST_WAIT_LOW;
			waitMidReg <= `ATB_RST_WAIT_MID;
			waitHighReg <= `ATB_RST_WAIT_HIGH;
			waitCntReg <= 2'b00;
			hreadyReg <= 1'b1;
			hrdataReg <= '0;
			pselReg <= '0;
			penableReg <= 1'b0;
			pwriteReg <= 1'b0;
			paddrReg <= '0;
			pwdataReg <= '0;
			regOffReg <= '0;
			regWrReg <= 1'b0;
		end else begin
			stateReg <= stateNext;
			waitLowReg <= waitLowNext;
			waitMidReg <= waitMidNext;
			waitHighReg <= waitHighNext;
			waitCntReg <= waitCntNext;
			hreadyReg <= hreadyNext;
			hrdataReg <= hrdataNext;
			pselReg <= pselNext;
			penableReg <= penableNext;
			pwriteReg <= pwriteNext;
			paddrReg <= paddrNext;
			pwdataReg <= pwdataNext;
			regOffReg <= regOffNext;
			regWrReg <= regWrNext;
		end
	end

	assign hreadyOut = hreadyReg;
	assign hresp = `ATB_HRESP_OKAY;
	assign hrdata = hrdataReg;
	assign psel = pselReg;
	assign penable = penableReg;
	assign pwrite = pwriteReg;
	assign paddr = paddrReg;
	assign pwdata = pwdataReg;

	// Helper: cycles spent in ACCESS for the current transfer
	logic [2:0] accCnt;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) accCnt <= '0;
		else if (stateReg == ATB_ACCESS) accCnt <= accCnt + 3'd1;
		else accCnt <= '0;
	end

	chk_setup_then_enable: assert property (
		@(posedge core_clk) disable iff (rst)
		(stateReg == ATB_SETUP) |=> penable && (psel != '0))
		else $error("enable not following setup");
	chk_wait_length: assert property (
		@(posedge core_clk) disable iff (rst)
		(stateReg == ATB_IDLE && stateNext == ATB_SETUP && decWait == 2'b11)
		|=> ##1 (stateReg == ATB_ACCESS)[*4] ##1 hreadyOut)
		else $error("three-wait access length wrong");
	chk_ready_low_busy: assert property (
		@(posedge core_clk) disable iff (rst)
		penable && (stateReg == ATB_ACCESS) |-> !hreadyOut)
		else $error("ready high during APB transfer");
	chk_access_bound: assert property (
		@(posedge core_clk) disable iff (rst)
		accCnt <= 3'd4)
		else $error("APB access exceeds five cycles");
	chk_read_data: assert property (
		@(posedge core_clk) disable iff (rst)
		(stateReg == ATB_ACCESS && stateNext == ATB_IDLE)
		|=> hreadyOut && hrdata == $past(prdata))
		else $error("read data not returned at end");
	chk_one_select: assert property (
		@(posedge core_clk) disable iff (rst)
		$onehot0(psel))
		else $error("more than one select");
	chk_reg_write: assert property (
		@(posedge core_clk) disable iff (rst)
		(stateReg == ATB_REGS && regWrReg &&
			regOffReg == `ATB_OFF_WAIT_MID)
		|=> waitMidReg == $past(hwdata))
		else $error("wait register write lost");
	chk_reg_ready: assert property (
		@(posedge core_clk) disable iff (rst)
		(stateReg == ATB_REGS) |-> !hreadyOut ##1 hreadyOut)
		else $error("register access timing wrong");
endmodule : atb_bridge
